// [verif/ib_mem_model.sv]
`timescale 1ns/1ps
module ib_mem_model
  import cache_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Internal bus from the cache
  input ib_req_t ib_i,
  input int lat_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  // Memory ignores the area bits, so the cached and uncached views alias.
  wire [31:0] key = {3'b000, ib_i.addr[28:0]};
  logic [31:0] mem [logic [31:0]];
  logic [31:0] rd_log [$];
  int n_rd = 0;
  int n_wr = 0;
  int cnt = 0;

  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      cnt <= 0;
    end else begin
      ack_o <= 1'b0;
      // Outside an answer the data lines toggle, so stale data never looks valid.
      rdata_o <= ~rdata_o;
      if (ib_i.req && !ack_o && cnt < lat_i) begin
        cnt <= cnt + 1;
      end else if (ib_i.req && !ack_o) begin
        cnt <= 0;
        ack_o <= 1'b1;
        if (ib_i.we) begin
          mem[key] = ib_i.wdata;
          n_wr++;
        end else begin
          rdata_o <= mem.exists(key) ? mem[key] : ~key;
          n_rd++;
          rd_log.push_back(ib_i.addr);
        end
      end
    end
  end
endmodule

// [verif/unified_set_assoc_cache_tb.sv]
`timescale 1ns/1ps
`include "cache_defines.svh"
module unified_set_assoc_cache_tb;
  import cache_pkg::*;
  localparam logic [31:0] CTRL_A = `CACHE_CONTROL_IDX << 2;
  logic mclk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [31:0] paddr_i = 0, pwdata_i = 0, prdata_o, cpu_rdata_o, ib_rdata, rd;
  logic pready_o, pslverr_o, cpu_ready_o, cpu_busy_o, ib_ack, err;
  logic cpu_req_i = 0, cpu_we_i = 0, cpu_ifetch_i = 0;
  logic [31:0] cpu_addr_i = 0, cpu_wdata_i = 0;
  ib_req_t ib;
  int bad_count = 0, tests_run = 0, lat = 0, cyc = 0, dr, dw, lt;

  unified_set_assoc_cache i_unified_set_assoc_cache (.mclk_i(mclk_i), .reset_i(reset_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .cpu_req_i(cpu_req_i), .cpu_we_i(cpu_we_i), .cpu_ifetch_i(cpu_ifetch_i),
    .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i), .cpu_be_i(4'hf),
    .cpu_ready_o(cpu_ready_o), .cpu_rdata_o(cpu_rdata_o), .cpu_busy_o(cpu_busy_o),
    .ib_o(ib), .ib_ack_i(ib_ack), .ib_rdata_i(ib_rdata));
  ib_mem_model i_ib_mem_model (.mclk_i(mclk_i), .reset_i(reset_i), .ib_i(ib), .lat_i(lat),
    .ack_o(ib_ack), .rdata_o(ib_rdata));

  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_n(string n, int e, int g);
    tests_run++;
    if (g != e) begin
      bad_count++;
      $display("mismatch %s expected %0d seen %0d", n, e, g);
    end
  endtask
  function automatic logic [31:0] mv(logic [31:0] a);
    return ~{3'b000, a[28:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
    int i;
    i = 0;
    @(posedge mclk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1;
    do begin
      @(posedge mclk_i);
      i++;
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task automatic ctl(logic [7:0] v);
    apb(1, CTRL_A, {24'h0, v});
  endtask
  // Waits out busy first: a request made while busy would be dropped silently.
  task automatic cpu(logic w, logic f, logic [31:0] a, logic [31:0] d);
    int r0, w0, i;
    i = 0;
    do begin
      @(posedge mclk_i);
      i++;
    end while (cpu_busy_o !== 1'b0);
    r0 = i_ib_mem_model.n_rd;
    w0 = i_ib_mem_model.n_wr;
    cpu_req_i <= 1;
    cpu_we_i <= w;
    cpu_ifetch_i <= f;
    cpu_addr_i <= a;
    cpu_wdata_i <= d;
    @(posedge mclk_i);
    cpu_req_i <= 0;
    lt = 0;
    do begin
      @(posedge mclk_i);
      lt++;
    end while (cpu_ready_o !== 1'b1);
    rd = cpu_rdata_o;
    dr = i_ib_mem_model.n_rd - r0;
    dw = i_ib_mem_model.n_wr - w0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(0, CTRL_A, 0);
    chk("ctrl reset", 32'h0000_0000, rd);
    apb(1, CTRL_A, 32'h0000_00ff);
    apb(0, CTRL_A, 0);
    chk("ctrl bits", 32'h0000_00ef, rd);
    apb(0, 32'h0000_0000, 0);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    ctl(8'h00);
    cpu(0, 0, 32'h0000_0124, 0);
    chk("off data", mv(32'h0000_0124), rd);
    chk_n("off words", 1, dr);
  endtask
  task automatic t_fill();
    lat = 2;
    ctl(8'h11);
    i_ib_mem_model.rd_log.delete();
    cpu(0, 0, 32'h0000_0124, 0);
    chk("fill data", mv(32'h0000_0124), rd);
    for (int j = 0; j < 4; j++) begin
      chk("fill order", {28'h000_0012, 2'(j + 2), 2'b00}, i_ib_mem_model.rd_log[j]);
    end
    cpu(0, 0, 32'h0000_0128, 0);
    chk("hit data", mv(32'h0000_0128), rd);
    chk_n("hit latency", 1, lt);
    chk_n("hit words", 0, dr);
    cpu_req_i <= 1;
    cpu_addr_i <= 32'h0000_0120;
    @(posedge mclk_i);
    cpu_addr_i <= 32'h0000_012c;
    @(posedge mclk_i);
    cpu_req_i <= 0;
    chk("b2b ready", 32'h1, {31'h0, cpu_ready_o});
    chk("b2b data", mv(32'h0000_0120), cpu_rdata_o);
    @(posedge mclk_i);
    chk("b2b ready", 32'h1, {31'h0, cpu_ready_o});
    chk("b2b data", mv(32'h0000_012c), cpu_rdata_o);
  endtask
  task automatic t_lru();
    for (int j = 1; j < 5; j++) begin
      cpu(0, 0, 32'h0000_0124 + (j << 10), 0);
      chk_n("set fill", 4, dr);
    end
    for (int j = 1; j < 5; j++) begin
      cpu(0, 0, 32'h0000_0124 + (j << 10), 0);
      chk_n("set hit", 0, dr);
    end
    cpu(0, 0, 32'h0000_0124, 0);
    chk_n("oldest gone", 4, dr);
  endtask
  task automatic t_thru();
    lat = 0;
    cpu(0, 0, 32'h2000_0924, 0);
    chk_n("thru words", 1, dr);
    chk("thru data", mv(32'h2000_0924), rd);
    cpu(1, 0, 32'h2000_0924, 32'h1234_5678);
    chk_n("thru write", 1, dw);
    cpu(0, 0, 32'h0000_0924, 0);
    chk("cached copy", mv(32'h0000_0924), rd);
    for (int j = 0; j < 2; j++) begin
      cpu(0, 0, 32'he000_0300, 0);
      chk_n("io words", 1, dr);
    end
  endtask
  task automatic t_write();
    int n0;
    ctl(8'h01);
    cpu(1, 0, 32'h0000_0d24, 32'h0bad_0001);
    chk_n("wt write", 1, dw);
    cpu(0, 0, 32'h0000_0d24, 0);
    chk("wt hit", 32'h0bad_0001, rd);
    cpu(1, 0, 32'h0000_3000, 32'h0bad_0002);
    chk_n("wt miss write", 1, dw);
    ctl(8'h21);
    cpu(1, 0, 32'h0000_0d24, 32'h0bad_0003);
    chk_n("wb hit write", 0, dw);
    cpu(0, 0, 32'h0000_0d24, 0);
    chk("wb hit", 32'h0bad_0003, rd);
    cpu(1, 0, 32'h4000_0d24, 0);
    cpu(0, 0, 32'h0000_0d24, 0);
    chk_n("line purge", 4, dr);
    ctl(8'h11);
    apb(0, CTRL_A, 0);
    chk("purge clear", 32'h0000_0001, rd);
    cpu(0, 0, 32'h0000_0924, 0);
    chk_n("all purged", 4, dr);
    // A dirty line in way 0 of a fresh set is the victim after four fills and drains on eviction.
    ctl(8'h21);
    for (int j = 0; j < 4; j++) cpu(j == 0, 0, 32'h0000_0a30 + (j << 10), 32'h0bad_0004);
    n0 = i_ib_mem_model.n_wr;
    cpu(0, 0, 32'h0000_1a30, 0);
    chk("busy in drain", 32'h1, {31'h0, cpu_busy_o});
    cpu(0, 0, 32'h2000_0a30, 0);
    chk_n("evict words", 4, i_ib_mem_model.n_wr - n0);
    chk("evicted data", 32'h0bad_0004, rd);
  endtask
  task automatic t_ways();
    for (int w = 0; w < 8; w++) begin
      ctl({2'(w), 6'h01});
      cpu(w > 3 ? 1'b0 : 1'b1, 0, 32'h6000_0040, (32'(w % 4 + 5) << 10) | 32'h4);
      if (w > 3) chk("tag way", (32'(w % 4 + 5) << 10) | 32'h4, rd);
    end
    cpu(0, 0, 32'h0000_1440, 0);
    chk_n("planted hit", 0, dr);
  endtask
  task automatic t_ram();
    ctl(8'h09);
    for (int w = 0; w < 2; w++) cpu(1, 0, 32'hc000_0044 | (w << 10), 32'hcafe_0000 + w);
    for (int j = 0; j < 4; j++) cpu(0, 0, 32'h0000_0044 + ((j % 3) << 14), 0);
    chk_n("two ways", 4, dr);
    for (int w = 0; w < 2; w++) begin
      cpu(0, 0, 32'hc000_0044 | (w << 10), 0);
      chk("ram word", 32'hcafe_0000 + w, rd);
    end
  endtask
  task automatic t_inhibit();
    for (int m = 0; m < 2; m++) begin
      ctl(m ? 8'h03 : 8'h05);
      for (int j = 0; j < 4; j++) begin
        cpu(0, j[1], 32'h0000_7000 + (m << 9) + (j[1] << 8), 0);
        if (j[0]) chk_n("fill gate", j[1] == m, dr > 0);
      end
    end
    reset_i <= 1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 0;
    apb(0, CTRL_A, 0);
    chk("ctrl manual reset", 32'h0000_0000, rd);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk_i);
    reset_i <= 0;
    t_regs();
    t_fill();
    t_lru();
    t_thru();
    t_write();
    t_ways();
    t_ram();
    t_inhibit();
    give_verdict();
  end
endmodule

// [verilog/cache_defines.svh]
`ifndef CACHE_DEFINES_SVH
`define CACHE_DEFINES_SVH

// Register index; the APB byte address is four times it, kept to the low 12 address bits.
`define CACHE_CONTROL_IDX 32'hffff_fe92
`define CACHE_CONTROL_RESET 8'h00
`define CTRL_PURGE_BIT 4

// Address partitions in bits 31 to 29.
`define AREA_MSB 31
`define AREA_LSB 29
`define AREA_CACHE 3'b000
`define AREA_THRU 3'b001
`define AREA_PURGE 3'b010
`define AREA_ADDR_ARRAY 3'b011
`define AREA_DATA_ARRAY 3'b110
`define AREA_IO 3'b111

// Address fields of one access.
`define TAG_MSB 28
`define TAG_LSB 10
`define IDX_MSB 9
`define IDX_LSB 4
`define WORD_MSB 3
`define WORD_LSB 2
`define DWIN_WAY_MSB 11
`define DWIN_WAY_LSB 10
`define AARR_VALID_BIT 2

`endif

// [verilog/cache_pkg.sv]
package cache_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FILL   = 3'b001,
    ST_RESP   = 3'b011,
    ST_EVICT  = 3'b010,
    ST_BYPASS = 3'b110
  } state_t;

  typedef struct packed {
    logic way_select_high;
    logic way_select_low;
    logic writeback_select;
    logic purge_all;
    logic dual_way_ram_mode;
    logic data_fill_inhibit;
    logic instr_fill_inhibit;
    logic cache_enable;
  } ctrl_t;

  typedef struct packed {
    logic we;
    logic ifetch;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } cpu_req_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } ib_req_t;

endpackage

// [verilog/unified_set_assoc_cache.sv]
// Operation
// - 4-kbyte unified four-way cache, both write policies.
// - 16-byte lines refilled by four longwords.
// - 64 entries per way indexed by A9..A4.
// - True LRU picks the victim way.
// - Any reset clears control register to zero.
// - Bits 7..6 pick way for address-array window.
// - Bit 5 selects write-through or write-back.
// - Purge bit clears all tags, valid, dirty and LRU bits, then self-clears.
// - Purge bit always reads as zero.
// - Bit 3 selects two-way cache plus RAM.
// - Two-way: ways 2,3 cache; 0,1 RAM.
// - Data fill inhibit blocks data miss allocation.
// - Instruction fill inhibit blocks fetch miss allocation.
// - Fill inhibits matter only while cache enabled.
// - Bit 0 enables cache; zero means unused.
// - Area 000 is cached when enabled.
// - Area 001 reaches memory bypassing cache.
// - Area 010 invalidates the matching line.
// - Area 011 accesses tags and valid bits.
// - Area 110 accesses line storage directly.
// - Read hit answers next cycle, back to back.
// - Refill wraps so requested longword comes last.
// - Write-through sends every write to memory.
// - Write-back hit sets dirty, no memory write.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "cache_defines.svh"
module unified_set_assoc_cache
  import cache_pkg::*;
#(
  parameter int WAYS = 4,
  parameter int ENTRIES = 64,
  parameter int LINE_WORDS = 4
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // APB register port
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Cache bus from the CPU
  input wire logic cpu_req_i,
  input wire logic cpu_we_i,
  input wire logic cpu_ifetch_i,
  input wire logic [31:0] cpu_addr_i,
  input wire logic [31:0] cpu_wdata_i,
  input wire logic [3:0] cpu_be_i,
  output logic cpu_ready_o,
  output logic [31:0] cpu_rdata_o,
  output logic cpu_busy_o,
  // Internal bus toward memory
  output ib_req_t ib_o,
  input wire logic ib_ack_i,
  input wire logic [31:0] ib_rdata_i
);

  // The array geometry is fixed by the address layout; other values cannot be served.
  if (WAYS != 4 || ENTRIES != 64 || LINE_WORDS != 4) begin : g_bad_geometry
    $error("Cache geometry must be 4 ways, 64 entries, 4 words per line.");
  end

  localparam logic [31:0] CTRL_IDX = `CACHE_CONTROL_IDX;

  ////////////////////////////////////////////////////////////////////////////
  // Control register over APB

  ctrl_t ctrl_q;
  logic purge_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  wire reg_hit = (paddr_i[11:0] == {CTRL_IDX[9:0], 2'b00});
  wire apb_setup = psel_i && !penable_i && !pready_q;
  wire apb_done = psel_i && penable_i && pready_q;
  wire ctrl_write = apb_done && pwrite_i && reg_hit;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q <= ctrl_t'(`CACHE_CONTROL_RESET);
      purge_q <= 1'b0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= apb_setup;
      if (apb_setup) begin
        pslverr_q <= !reg_hit;
        prdata_q <= reg_hit ? {24'h00_0000, ctrl_q} : 32'h0000_0000;
      end
      if (ctrl_write) begin
        ctrl_q <= ctrl_t'({pwdata_i[7:5], 1'b0, pwdata_i[3:0]});
      end
      purge_q <= ctrl_write && pwdata_i[`CTRL_PURGE_BIT];
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Arrays and lookup

  logic [18:0] tag_q [0:3][0:63];
  logic [3:0] valid_q [0:63];
  logic [3:0] dirty_q [0:63];
  logic [5:0] lru_q [0:63];
  logic [31:0] data_mem [0:1023];

  state_t state_q;
  cpu_req_t req_q;
  logic [1:0] way_q;
  logic [1:0] cnt_q;
  logic [1:0] fw_q;
  logic evict_q;
  logic [31:0] wbuf_q [0:3];
  logic [31:0] wbuf_addr_q;
  logic ready_q;
  logic [31:0] rdata_q;
  ib_req_t ib_q;

  // Six order bits, one per way pair (01,02,03,12,13,23); a one means the lower way was used later.
  function automatic logic [5:0] lru_touch(input logic [5:0] l, input logic [1:0] w);
    logic [5:0] n;
    n = l;
    case (w)
      2'd0: begin
        n[0] = 1'b1;
        n[1] = 1'b1;
        n[2] = 1'b1;
      end
      2'd1: begin
        n[0] = 1'b0;
        n[3] = 1'b1;
        n[4] = 1'b1;
      end
      2'd2: begin
        n[1] = 1'b0;
        n[3] = 1'b0;
        n[5] = 1'b1;
      end
      default: begin
        n[2] = 1'b0;
        n[4] = 1'b0;
        n[5] = 1'b0;
      end
    endcase
    return n;
  endfunction

  // The way every order bit points away from is the oldest one.
  function automatic logic [1:0] lru_victim(input logic [5:0] l, input logic dual);
    logic [1:0] v;
    v = 2'd3;
    if (dual) begin
      v = l[5] ? 2'd3 : 2'd2;
    end else if (!l[0] && !l[1] && !l[2]) begin
      v = 2'd0;
    end else if (l[0] && !l[3] && !l[4]) begin
      v = 2'd1;
    end else if (l[1] && l[3] && !l[5]) begin
      v = 2'd2;
    end
    return v;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
    logic [31:0] m;
    m = o;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[8*b +: 8] = n[8*b +: 8];
      end
    end
    return m;
  endfunction

  wire [2:0] a_area = cpu_addr_i[`AREA_MSB:`AREA_LSB];
  wire [18:0] a_tag = cpu_addr_i[`TAG_MSB:`TAG_LSB];
  wire [5:0] a_idx = cpu_addr_i[`IDX_MSB:`IDX_LSB];
  wire [1:0] a_word = cpu_addr_i[`WORD_MSB:`WORD_LSB];
  wire [1:0] dwin_way = cpu_addr_i[`DWIN_WAY_MSB:`DWIN_WAY_LSB];
  wire [1:0] aarr_way = {ctrl_q.way_select_high, ctrl_q.way_select_low};
  wire [5:0] r_idx = req_q.addr[`IDX_MSB:`IDX_LSB];
  wire [1:0] r_word = req_q.addr[`WORD_MSB:`WORD_LSB];

  logic [3:0] hit_w;
  for (genvar w = 0; w < 4; w++) begin : g_way
    // In dual mode ways 0 and 1 are RAM and never take part in lookup.
    assign hit_w[w] = valid_q[a_idx][w] && (tag_q[w][a_idx] == a_tag)
                      && (!ctrl_q.dual_way_ram_mode || w >= 2);
  end

  wire hit = |hit_w;
  wire [1:0] hit_way = hit_w[3] ? 2'd3 : hit_w[2] ? 2'd2 : hit_w[1] ? 2'd1 : 2'd0;
  wire [1:0] victim = lru_victim(lru_q[a_idx], ctrl_q.dual_way_ram_mode);
  wire accept = cpu_req_i && (state_q == ST_IDLE) && !purge_q;
  wire is_cached = (a_area == `AREA_CACHE) && ctrl_q.cache_enable;
  wire inhibit = cpu_ifetch_i ? ctrl_q.instr_fill_inhibit : ctrl_q.data_fill_inhibit;
  wire cached_hit = accept && is_cached && hit;
  wire do_alloc = accept && is_cached && !hit && !inhibit && !(cpu_we_i && !ctrl_q.writeback_select);
  wire win_purge = accept && (a_area == `AREA_PURGE);
  wire win_aarr = accept && (a_area == `AREA_ADDR_ARRAY);
  wire win_darr = accept && (a_area == `AREA_DATA_ARRAY);
  wire [9:0] hit_addr = {hit_way, a_idx, a_word};
  wire [9:0] darr_addr = {dwin_way, a_idx, a_word};
  wire [9:0] resp_addr = {way_q, r_idx, r_word};
  wire [9:0] fill_addr = {way_q, r_idx, fw_q};
  wire [1:0] cnt_next = cnt_q + 2'd1;

  // One write port into line storage; only one source can be active in a cycle.
  logic mem_we;
  logic [9:0] mem_waddr;
  logic [31:0] mem_wdata;
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = hit_addr;
    mem_wdata = merge(data_mem[hit_addr], cpu_wdata_i, cpu_be_i);
    if (state_q == ST_FILL && ib_ack_i) begin
      mem_we = 1'b1;
      mem_waddr = fill_addr;
      mem_wdata = ib_rdata_i;
    end else if (state_q == ST_RESP && req_q.we) begin
      mem_we = 1'b1;
      mem_waddr = resp_addr;
      mem_wdata = merge(data_mem[resp_addr], req_q.wdata, req_q.be);
    end else if (cached_hit && cpu_we_i) begin
      mem_we = 1'b1;
    end else if (win_darr && cpu_we_i) begin
      mem_we = 1'b1;
      mem_waddr = darr_addr;
      mem_wdata = merge(data_mem[darr_addr], cpu_wdata_i, cpu_be_i);
    end
  end

  // Line storage is plain memory; purge clears only its bookkeeping.
  always_ff @(posedge mclk_i) begin
    if (mem_we) begin
      data_mem[mem_waddr] <= mem_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tags, valid, dirty and replacement order

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int e = 0; e < 64; e++) begin
        valid_q[e] <= 4'h0;
        dirty_q[e] <= 4'h0;
        lru_q[e] <= 6'h00;
        for (int w = 0; w < 4; w++) begin
          tag_q[w][e] <= 19'h0_0000;
        end
      end
    end else if (purge_q) begin
      for (int e = 0; e < 64; e++) begin
        valid_q[e] <= 4'h0;
        dirty_q[e] <= 4'h0;
        lru_q[e] <= 6'h00;
        for (int w = 0; w < 4; w++) begin
          tag_q[w][e] <= 19'h0_0000;
        end
      end
    end else if (win_purge) begin
      valid_q[a_idx] <= valid_q[a_idx] & ~hit_w;
    end else if (win_aarr && cpu_we_i) begin
      tag_q[aarr_way][a_idx] <= cpu_wdata_i[`TAG_MSB:`TAG_LSB];
      valid_q[a_idx][aarr_way] <= cpu_wdata_i[`AARR_VALID_BIT];
    end else if (cached_hit) begin
      lru_q[a_idx] <= lru_touch(lru_q[a_idx], hit_way);
      if (cpu_we_i && ctrl_q.writeback_select) begin
        dirty_q[a_idx][hit_way] <= 1'b1;
      end
    end else if (do_alloc) begin
      tag_q[victim][a_idx] <= a_tag;
      valid_q[a_idx][victim] <= 1'b1;
      dirty_q[a_idx][victim] <= cpu_we_i;
      lru_q[a_idx] <= lru_touch(lru_q[a_idx], victim);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      req_q <= '0;
      way_q <= 2'd0;
      cnt_q <= 2'd0;
      fw_q <= 2'd0;
      evict_q <= 1'b0;
      wbuf_addr_q <= 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
        wbuf_q[i] <= 32'h0000_0000;
      end
      ready_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ib_q <= '0;
    end else begin
      ready_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            req_q <= '{we: cpu_we_i, ifetch: cpu_ifetch_i, addr: cpu_addr_i, wdata: cpu_wdata_i, be: cpu_be_i};
            if (win_purge || win_aarr || win_darr) begin
              ready_q <= 1'b1;
              rdata_q <= win_darr ? data_mem[darr_addr]
                       : win_aarr ? {3'b000, tag_q[aarr_way][a_idx], 7'h00, valid_q[a_idx][aarr_way], 2'b00}
                       : 32'h0000_0000;
            end else if (cached_hit && (!cpu_we_i || ctrl_q.writeback_select)) begin
              ready_q <= 1'b1;
              rdata_q <= data_mem[hit_addr];
            end else if (do_alloc) begin
              way_q <= victim;
              cnt_q <= 2'd0;
              fw_q <= a_word + 2'd1;
              evict_q <= valid_q[a_idx][victim] && dirty_q[a_idx][victim];
              wbuf_addr_q <= {3'b000, tag_q[victim][a_idx], a_idx, 4'h0};
              for (int i = 0; i < 4; i++) begin
                wbuf_q[i] <= data_mem[{victim, a_idx, i[1:0]}];
              end
              ib_q <= '{req: 1'b1, we: 1'b0, addr: {cpu_addr_i[31:4], a_word + 2'd1, 2'b00},
                        wdata: 32'h0000_0000, be: 4'hf};
              state_q <= ST_FILL;
            end else begin
              // Cache-through, I/O, disabled, inhibited or write-through writes go out unchanged.
              ib_q <= '{req: 1'b1, we: cpu_we_i, addr: cpu_addr_i, wdata: cpu_wdata_i, be: cpu_be_i};
              state_q <= ST_BYPASS;
            end
          end
        end
        ST_FILL: begin
          if (ib_ack_i) begin
            cnt_q <= cnt_next;
            fw_q <= fw_q + 2'd1;
            ib_q.addr[3:2] <= fw_q + 2'd1;
            if (cnt_q == 2'd3) begin
              ib_q.req <= 1'b0;
              state_q <= ST_RESP;
            end
          end
        end
        ST_RESP: begin
          // The last fetched word is in the array now, one cycle after its arrival.
          ready_q <= 1'b1;
          rdata_q <= req_q.we ? 32'h0000_0000 : data_mem[resp_addr];
          cnt_q <= 2'd0;
          if (evict_q) begin
            ib_q <= '{req: 1'b1, we: 1'b1, addr: wbuf_addr_q, wdata: wbuf_q[0], be: 4'hf};
            state_q <= ST_EVICT;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_EVICT: begin
          // The refill had priority; the displaced dirty line drains only now.
          if (ib_ack_i) begin
            cnt_q <= cnt_next;
            ib_q.addr[3:2] <= cnt_next;
            ib_q.wdata <= wbuf_q[cnt_next];
            if (cnt_q == 2'd3) begin
              ib_q.req <= 1'b0;
              evict_q <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
        end
        ST_BYPASS: begin
          if (ib_ack_i) begin
            ib_q.req <= 1'b0;
            ready_q <= 1'b1;
            rdata_q <= req_q.we ? 32'h0000_0000 : ib_rdata_i;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  logic busy_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (accept && !(win_purge || win_aarr || win_darr)
                 && !(cached_hit && (!cpu_we_i || ctrl_q.writeback_select)))
                // Nothing holds busy in idle, so a control write blocks only the purge cycle.
                || (busy_q && (state_q != ST_IDLE) && !(state_q == ST_RESP && !evict_q)
                    && !(state_q == ST_BYPASS && ib_ack_i)
                    && !(state_q == ST_EVICT && ib_ack_i && cnt_q == 2'd3)) || ctrl_write;
    end
  end

  assign cpu_ready_o = ready_q;
  assign cpu_rdata_o = rdata_q;
  assign cpu_busy_o = busy_q;
  assign ib_o = ib_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence s_fill_last;
    (state_q == ST_FILL) && ib_ack_i && (cnt_q == 2'd3);
  endsequence

  sequence s_resp_then_idle;
    (state_q == ST_RESP) && cpu_ready_o == 1'b0 ##1 cpu_ready_o;
  endsequence

  a_purge_reads_zero: assert property (prdata_o[`CTRL_PURGE_BIT] == 1'b0)
    else $error("Purge bit read back as one.");
  a_purge_clears: assert property (purge_q |=> !purge_q && valid_q[0] == 4'h0 && lru_q[63] == 6'h00)
    else $error("Purge did not clear state or did not self-clear.");
  a_hit_one_cycle: assert property (cached_hit && !cpu_we_i |=> cpu_ready_o && state_q == ST_IDLE)
    else $error("Read hit did not answer in one cycle.");
  a_fill_four_words: assert property (s_fill_last |=> s_resp_then_idle)
    else $error("Refill did not end after the fourth word.");
  a_fill_wrap_order: assert property (s_fill_last |-> ib_o.addr[3:2] == req_q.addr[3:2])
    else $error("Requested longword was not fetched last.");
  a_disabled_bypass: assert property (accept && !ctrl_q.cache_enable && (a_area == `AREA_CACHE)
                                      |=> state_q == ST_BYPASS)
    else $error("Access used the cache while disabled.");
  a_through_write: assert property (accept && is_cached && cpu_we_i && !ctrl_q.writeback_select
                                    |=> state_q == ST_BYPASS && ib_o.req && ib_o.we)
    else $error("Write-through write did not go to memory.");
  a_wb_hit_dirty: assert property (cached_hit && cpu_we_i && ctrl_q.writeback_select
                                   |=> dirty_q[$past(a_idx)][$past(hit_way)] && !ib_o.req)
    else $error("Write-back hit did not mark the line dirty.");
  a_dual_no_hit: assert property (ctrl_q.dual_way_ram_mode |-> !hit_w[0] && !hit_w[1])
    else $error("RAM way took part in lookup.");
  a_inhibit_noalloc: assert property (accept && is_cached && !hit && inhibit |=> state_q == ST_BYPASS)
    else $error("Inhibited miss allocated a line.");

endmodule
